// [test_tx_descriptor_decode.sv]
/* bench: random descriptor chains through txd_decode; assumes txd_mem_model answers. */
`timescale 1ns/10ps
module test_tx_descriptor_decode
	import txd_pkg::*;
;
	logic clk_sys, srst, start, frag_done, rd_req, rd_valid, wr_req, wr_ack;
	logic desc_valid, desc_done, not_ready, chain_end, busy;
	logic [39:0] start_addr, rd_addr, wr_addr;
	logic [63:0] rd_data, wr_data;
	txd_ctrl_t desc_ctrl;
	logic [31:0] seed = 32'h0000_150b;
	int err_count, total_checks;
	int done_count;
	txd_decode DUT (.*);
	txd_mem_model u_mem (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic txd_ctrl_t exp_ctrl(input logic [63:0] w);
		return '{w[15:0], w[16] ? TXD_RND_NONE : w[17] ? TXD_RND_WORD : TXD_RND_DWORD,
			w[18], w[19], w[20], !w[21] || |w[20:18], w[27:24]};
	endfunction : exp_ctrl
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys) begin
		if (desc_done === 1'b1) done_count++;
	end
	task automatic walk(input int n, input logic own);
		logic [39:0] a [7];
		logic [63:0] c [7];
		int t;
		for (int k = 0; k < n; k++) a[k] = {rnd(), 8'h00} | 40'(k * 16); // aligned
		for (int k = 0; k < n; k++) begin
			c[k] = {rnd(), rnd() & 32'h7fff_ffff};
			c[k][17:16] = 2'(k); // every rounding code
			c[k][31] = own && k == n - 1;
			if (k == 0) c[k][27:24] = FRAG_NONE;
			if (k == 1) c[k][21:18] = 4'h7; // every checksum request, crc kept
			else if (k == 2) c[k][21:18] = 4'h8; // crc inhibit alone
			else if (|c[k][20:18]) c[k][21] = 1'b0;
			u_mem.mem[a[k]] = {24'(rnd()), k == n - 1 ? NULL_PTR : a[k + 1]};
			u_mem.mem[a[k] + 40'h8] = c[k];
		end
		done_count = 0;
		start_addr = a[0];
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		for (int k = 0; k < n; k++) begin
			t = 0;
			while (desc_valid !== 1'b1 && not_ready !== 1'b1 && t < 99) begin
				@(negedge clk_sys);
				t++;
			end
			check(t < 99, "no descriptor");
			if (c[k][31]) check(not_ready && !desc_valid, "owned");
			else check(desc_ctrl === exp_ctrl(c[k]), "ctrl");
			frag_done = !c[k][31] && c[k][27:24] != FRAG_NONE;
			@(negedge clk_sys);
			frag_done = 1'b0;
		end
		t = 0;
		while (busy !== 1'b0 && t < 99) begin
			@(negedge clk_sys);
			t++;
		end
		repeat (2) @(negedge clk_sys);
		check(chain_end === !own && busy === 1'b0, "end");
		check(done_count == n - int'(own), "done count");
		for (int k = 0; k < n; k++) check(u_mem.mem[a[k] + 40'h8] === (c[k] | 64'h8000_0000), "wb");
	endtask : walk
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	initial begin
		{srst, start, frag_done} = 3'h4;
		start_addr = ADDR_RESET;
		repeat (8) @(negedge clk_sys);
		srst = 1'b0;
		walk(6, 1'b0);
		u_mem.slow = 1'b1;
		walk(5, 1'b1);
		wrap_up();
	end
endmodule : test_tx_descriptor_decode

// [txd_chk_sva.sv]
/* txd_chk: port assertions for txd_decode; assumes one clock, srst, bind below. */
`timescale 1ns/10ps
module txd_chk
	import txd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        rd_req,
	input wire logic [63:0] rd_data,
	input wire logic        wr_req,
	input wire logic [63:0] wr_data,
	input wire logic        desc_valid,
	input wire txd_ctrl_t   desc_ctrl,
	input wire logic        chain_end
);
	logic [63:0] rd_reg;
	always_ff @(posedge clk_sys) rd_reg <= rd_data;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	tag_pass_a: assert property (desc_valid |-> desc_ctrl.frame_tag == rd_reg[15:0])
		else $error("tag");
	sum_bits_a: assert property (desc_valid |-> {desc_ctrl.ip_sum_insert,
		desc_ctrl.udp_sum_insert, desc_ctrl.tcp_sum_insert} == rd_reg[20:18]) else $error("sum");
	round_sel_a: assert property (desc_valid |-> desc_ctrl.length_rounding == (rd_reg[16] ?
		TXD_RND_NONE : rd_reg[17] ? TXD_RND_WORD : TXD_RND_DWORD)) else $error("round");
	crc_keep_a: assert property (desc_valid |-> desc_ctrl.crc_append ==
		(!rd_reg[21] || |rd_reg[20:18])) else $error("crc");
	frag_num_a: assert property (desc_valid |-> desc_ctrl.fragment_total == rd_reg[27:24])
		else $error("frag");
	owned_skip_a: assert property (desc_valid |-> !rd_reg[31]) else $error("owned");
	wback_flag_a: assert property (wr_req |-> wr_data[31]) else $error("flag");
	chain_stop_a: assert property ($rose(chain_end) |-> !rd_req ##1 !rd_req) else $error("stop");
	cover property (desc_valid && desc_ctrl.tcp_sum_insert);
	cover property ($rose(chain_end));
	cover property (wr_req ##1 !wr_req);
endmodule : txd_chk
bind txd_decode txd_chk u_chk (
	.clk_sys    (clk_sys),
	.srst       (srst),
	.rd_req     (rd_req),
	.rd_data    (rd_data),
	.wr_req     (wr_req),
	.wr_data    (wr_data),
	.desc_valid (desc_valid),
	.desc_ctrl  (desc_ctrl),
	.chain_end  (chain_end)
);

// [txd_decode.sv]
/*
 * txd_decode: walks a chain of transmit descriptors, reads the link word and the
 * control word of each, hands decoded control to the fragment engine, then writes
 * the ownership flag back. assumes a simple memory read/write handshake where
 * rd_valid and wr_ack are one-cycle answers to a held request.
 */
// Function
// - link word at descriptor offset zero is read as one 64-bit word.
// - only low 40 bits of the link pointer address the next descriptor.
// - zero link pointer ends the chain; nothing is fetched from address zero.
// - low sixteen control bits are passed on as the frame tag.
// - bits 17:16 pick rounding: 00 double word, 10 word, x1 none.
// - bit 18 set requests tcp checksum insertion by the device.
// - bit 19 set requests udp checksum insertion by the device.
// - bit 20 set requests ip header checksum insertion by the device.
// - device always appends crc on frames where it inserts checksums.
// - bit 21 set inhibits crc append unless a checksum is inserted.
// - fetch only descriptors with ownership flag clear; set it when done. code reads an owned one, then stops with not_ready.
// - bits 27:24 give fragment count; zero means no data to move.
`timescale 1ns/10ps
module txd_decode
	import txd_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              start,
	input  wire logic [39:0]       start_addr,
	output logic                   rd_req,
	output logic [39:0]            rd_addr,
	input  wire logic              rd_valid,
	input  wire logic [63:0]       rd_data,
	output logic                   wr_req,
	output logic [39:0]            wr_addr,
	output logic [63:0]            wr_data,
	input  wire logic              wr_ack,
	output logic                   desc_valid,
	output txd_ctrl_t              desc_ctrl,
	input  wire logic              frag_done,
	output logic                   desc_done,
	output logic                   not_ready,
	output logic                   chain_end,
	output logic                   busy
);

	typedef enum logic [2:0] {
		TXD_IDLE,
		TXD_RD_LINK,
		TXD_RD_CTRL,
		TXD_WAIT_DMA,
		TXD_WR_BACK
	} txd_state_t;

	txd_state_t   state_reg;
	logic [39:0]  base_reg;
	logic [39:0]  link_reg;
	logic [63:0]  ctrl_word_reg;
	logic [1:0]   round_bits;
	logic         any_sum;
	txd_round_t   round_next;
	txd_ctrl_t    ctrl_next;
	logic         start_take;
	logic         link_take;
	logic         ctrl_take;
	logic         owned_seen;
	logic         good_take;
	logic         no_frags;
	logic         dma_take;
	logic         ack_take;
	logic         link_live;

	// rounding decode
	always_comb begin
		round_bits = rd_data[ROUND_LSB +: 2];
		if (round_bits[0]) begin
			round_next = TXD_RND_NONE;
		end else if (round_bits[1]) begin
			round_next = TXD_RND_WORD;
		end else begin
			round_next = TXD_RND_DWORD;
		end
	end

	// control word decode
	always_comb begin
		any_sum = rd_data[TCP_BIT] | rd_data[UDP_BIT] | rd_data[IP_BIT];
		ctrl_next.frame_tag = rd_data[TAG_LSB +: TAG_W];
		ctrl_next.length_rounding = round_next;
		ctrl_next.tcp_sum_insert = rd_data[TCP_BIT];
		ctrl_next.udp_sum_insert = rd_data[UDP_BIT];
		ctrl_next.ip_sum_insert = rd_data[IP_BIT];
		ctrl_next.crc_append = ~rd_data[INHIBIT_BIT] | any_sum;
		ctrl_next.fragment_total = rd_data[FRAG_LSB +: FRAG_W];
	end

	// handshake events of the walk
	assign start_take = (state_reg == TXD_IDLE) && start;
	assign link_take  = (state_reg == TXD_RD_LINK) && rd_valid;
	assign ctrl_take  = (state_reg == TXD_RD_CTRL) && rd_valid;
	assign owned_seen = ctrl_take && rd_data[OWNED_BIT];
	assign good_take  = ctrl_take && !rd_data[OWNED_BIT];
	assign no_frags   = rd_data[FRAG_LSB +: FRAG_W] == FRAG_NONE;
	assign dma_take   = (state_reg == TXD_WAIT_DMA) && frag_done;
	assign ack_take   = (state_reg == TXD_WR_BACK) && wr_ack;
	assign link_live  = link_reg != NULL_PTR;

	// descriptor walk
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= TXD_IDLE;
		end else begin
			case (state_reg)
				TXD_IDLE: begin
					if (start) begin
						state_reg <= TXD_RD_LINK;
					end
				end
				TXD_RD_LINK: begin
					if (rd_valid) begin
						state_reg <= TXD_RD_CTRL;
					end
				end
				TXD_RD_CTRL: begin
					if (owned_seen) begin
						state_reg <= TXD_IDLE;
					end else if (good_take && no_frags) begin
						state_reg <= TXD_WR_BACK;
					end else if (good_take) begin
						state_reg <= TXD_WAIT_DMA;
					end
				end
				TXD_WAIT_DMA: begin
					if (frag_done) begin
						state_reg <= TXD_WR_BACK;
					end
				end
				TXD_WR_BACK: begin
					if (wr_ack && link_live) begin
						state_reg <= TXD_RD_LINK;
					end else if (wr_ack) begin
						state_reg <= TXD_IDLE;
					end
				end
				default: begin
					state_reg <= TXD_IDLE;
				end
			endcase
		end
	end

	// descriptor base, link and control word
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			base_reg      <= ADDR_RESET;
			link_reg      <= ADDR_RESET;
			ctrl_word_reg <= WORD_RESET;
		end else begin
			if (start_take) begin
				base_reg <= start_addr;
			end else if (ack_take && link_live) begin
				base_reg <= link_reg;
			end
			if (link_take) begin
				link_reg <= rd_data[ADDR_W-1:0];
			end
			if (ctrl_take) begin
				ctrl_word_reg <= rd_data;
			end
		end
	end

	// read request and address
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_req  <= 1'b0;
			rd_addr <= ADDR_RESET;
		end else if (start_take) begin
			rd_req  <= 1'b1;
			rd_addr <= start_addr + LINK_OFFSET;
		end else if (link_take) begin
			rd_addr <= base_reg + CTRL_OFFSET;
		end else if (ctrl_take) begin
			rd_req <= 1'b0;
		end else if (ack_take && link_live) begin
			rd_req  <= 1'b1;
			rd_addr <= link_reg + LINK_OFFSET;
		end
	end

	// ownership write-back
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_req  <= 1'b0;
			wr_addr <= ADDR_RESET;
			wr_data <= WORD_RESET;
		end else if (good_take && no_frags) begin
			wr_req  <= 1'b1;
			wr_addr <= base_reg + CTRL_OFFSET;
			wr_data <= rd_data | (64'h1 << OWNED_BIT);
		end else if (dma_take) begin
			wr_req  <= 1'b1;
			wr_addr <= base_reg + CTRL_OFFSET;
			wr_data <= ctrl_word_reg | (64'h1 << OWNED_BIT);
		end else if (ack_take) begin
			wr_req <= 1'b0;
		end
	end

	// one-cycle event pulses
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			desc_valid <= 1'b0;
			desc_done  <= 1'b0;
			not_ready  <= 1'b0;
		end else begin
			desc_valid <= good_take;
			desc_done  <= ack_take;
			not_ready  <= owned_seen;
		end
	end

	// walk status
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			chain_end <= 1'b0;
			busy      <= 1'b0;
		end else if (start_take) begin
			chain_end <= 1'b0;
			busy      <= 1'b1;
		end else if (owned_seen) begin
			busy <= 1'b0;
		end else if (ack_take && !link_live) begin
			chain_end <= 1'b1;
			busy      <= 1'b0;
		end
	end

	// decoded control held for the fragment engine
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			desc_ctrl <= CTRL_RESET;
		end else if (state_reg == TXD_RD_CTRL && rd_valid && !rd_data[OWNED_BIT]) begin
			desc_ctrl <= ctrl_next;
		end
	end

endmodule : txd_decode

// [txd_mem_model.sv]
/* txd_mem_model: host memory of descriptors; assumes the bench fills mem and sets slow. */
`timescale 1ns/10ps
module txd_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        rd_req,
	input  wire logic [39:0] rd_addr,
	output logic             rd_valid,
	output logic [63:0]      rd_data,
	input  wire logic        wr_req,
	input  wire logic [39:0] wr_addr,
	input  wire logic [63:0] wr_data,
	output logic             wr_ack
);
	logic [63:0] mem [logic [39:0]]; // 64-bit words on quad-word addresses
	logic [1:0]  wait_reg = 2'h0;
	logic        slow = 1'b0;
	initial {rd_valid, wr_ack, rd_data} = '0;
	always @(posedge clk_sys) begin
		rd_valid <= 1'b0;
		wr_ack <= 1'b0;
		rd_data <= ~rd_data;
		if ((rd_req && !rd_valid) || (wr_req && !wr_ack)) begin
			wait_reg <= wait_reg + 2'h1;
			if (wait_reg >= {slow, slow}) begin
				wait_reg <= 2'h0;
				rd_valid <= rd_req;
				wr_ack <= wr_req;
				if (rd_req) rd_data <= mem[rd_addr];
				if (wr_req) mem[wr_addr] = wr_data; // owned flag set by device
			end
		end
	end
endmodule : txd_mem_model

// [txd_pkg.sv]
/*
 * txd_pkg: field layout, offsets and types for the transmit descriptor decoder.
 * assumes descriptors are 64-bit words in system memory, 40-bit addressing.
 */
package txd_pkg;

	localparam int          ADDR_W          = 40;
	localparam int          WORD_W          = 64;
	localparam logic [39:0] LINK_OFFSET     = 40'h00_0000_0000;
	localparam logic [39:0] CTRL_OFFSET     = 40'h00_0000_0008;
	localparam logic [39:0] NULL_PTR        = 40'h00_0000_0000;
	localparam logic [39:0] ADDR_RESET      = 40'h00_0000_0000;
	localparam logic [63:0] WORD_RESET      = 64'h0000_0000_0000_0000;
	localparam int          TAG_LSB         = 0;
	localparam int          TAG_W           = 16;
	localparam int          ROUND_LSB       = 16;
	localparam int          TCP_BIT         = 18;
	localparam int          UDP_BIT         = 19;
	localparam int          IP_BIT          = 20;
	localparam int          INHIBIT_BIT     = 21;
	localparam int          FRAG_LSB        = 24;
	localparam int          FRAG_W          = 4;
	localparam int          OWNED_BIT       = 31;
	localparam logic [3:0]  FRAG_NONE       = 4'h0;

	typedef enum logic [1:0] {
		TXD_RND_DWORD,
		TXD_RND_WORD,
		TXD_RND_NONE
	} txd_round_t;

	typedef struct packed {
		logic [15:0] frame_tag;
		txd_round_t  length_rounding;
		logic        tcp_sum_insert;
		logic        udp_sum_insert;
		logic        ip_sum_insert;
		logic        crc_append;
		logic [3:0]  fragment_total;
	} txd_ctrl_t;

	localparam txd_ctrl_t CTRL_RESET = '{
		frame_tag:       16'h0000,
		length_rounding: TXD_RND_DWORD,
		tcp_sum_insert:  1'b0,
		udp_sum_insert:  1'b0,
		ip_sum_insert:   1'b0,
		crc_append:      1'b1,
		fragment_total:  4'h0
	};

endpackage : txd_pkg
